// >>> design/lbc_pkg.sv
/*
  shared constants and carrier structs for the local bus control block.
  assumes one clock domain; the cpu core side issues one access at a time.
*/
package lbc_pkg;
  localparam int unsigned ADDR_W       = 20;
  localparam int unsigned GCS_N        = 8;
  localparam int unsigned BLK_W        = 10;  // 1 kbyte block granularity
  localparam int unsigned IRQ_W        = 8;
  localparam logic [7:0]  COPROC_IRQ   = 8'h10;
  // reset window of the upper select
  localparam logic [19:0] UCS_RST_LO   = 20'hffc00;
  localparam logic [19:0] UCS_RST_HI   = 20'hfffff;
  localparam logic        LCS_RST_EN   = 1'b0;
  localparam logic        GCS_RST_EN   = 1'b0;
  localparam logic        PORT_RST_VAL = 1'b1;

  // one select window
  typedef struct packed {
    logic              en;
    logic              mem;    // matches memory cycles
    logic              io;     // matches i/o cycles
    logic              no_rdy; // ignore the ready input
    logic [ADDR_W-1:0] lo;
    logic [ADDR_W-1:0] hi;
  } win_cfg_t;

  // access request from the core
  typedef struct packed {
    logic              write;
    logic              io;
    logic              coproc;
    logic              locked;
    logic [ADDR_W-1:0] addr;
  } bus_req_t;
endpackage

// >>> design/win_match.sv
/*
  address window comparator for one chip select.
  assumes configuration is stable while an access is in flight.
*/
`timescale 1ns/100ps
module win_match
  import lbc_pkg::*;
(
  input  wire win_cfg_t          cfg_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic              io_i,
  output logic                   hit_o
);
  always_comb begin
    hit_o = cfg_i.en && (io_i ? cfg_i.io : cfg_i.mem) &&
            (addr_i >= cfg_i.lo) && (addr_i <= cfg_i.hi);
  end
endmodule // win_match

// >>> design/sel_pin.sv
/*
  one generic select pin with output port fallback.
  assumes the hit input is already qualified with an active access.
*/
`timescale 1ns/100ps
module sel_pin
  import lbc_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic sel_en_i,
  input  wire logic hit_i,
  input  wire logic port_val_i,
  output logic      pin_n_o
);
  // R16 select or port bit
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_n_o <= 1'b1;
    end else begin
      pin_n_o <= sel_en_i ? ~hit_i : port_val_i;
    end
  end
endmodule // sel_pin

// >>> design/local_bus_ctrl.sv
/*
  local bus control: strobes, ready, transceiver control, lock, bus
  takeover, coprocessor signals and chip selects.
  assumes the core presents one request at a time and holds it until
  done; pins are synchronous to clk_i; pads resolve the lock pin.
*/
// Function
// R1 - assert read strobe during read cycles
// R2 - assert write strobe during write cycles
// R3 - cycle ends only on ready, unless the select ignores ready
// R4 - transceiver enable active only while data moves
// R5 - direction output shows data flowing out or in
// R6 - while locked, no takeover grant and cycle not broken
// R7 - lock pin is a weakly held input during reset, never driven low
// R8 - give bus to external master only at unlocked instruction boundaries
// R9 - on acknowledge, data and control outputs are floated
// R10 - coprocessor select asserted on coprocessor accesses
// R11 - exception sampled at numerics start raises interrupt type 16
// R12 - coprocessor transfer request flagged as pending transfer
// R13 - upper select active for cycles in its programmed range
// R14 - upper select decodes memory 0ffc00h to 0fffffh after reset
// R15 - lower select memory only, inactive until programmed
// R16 - generic pins select when enabled, else output port bits
// R17 - generic pin values readable internally
// R18 - selects active low, high when no matching access
`timescale 1ns/100ps
module local_bus_ctrl
  import lbc_pkg::*;
#(
  parameter int unsigned N_GCS = GCS_N
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // core side
  input  wire logic             req_valid_i,
  input  wire bus_req_t         req_i,
  input  wire logic             insn_boundary_i,
  input  wire logic             numerics_start_i,
  output logic                  req_done_o,
  output logic                  irq_o,
  output logic [IRQ_W-1:0]      irq_type_o,
  output logic                  xfer_pending_o,
  output logic [N_GCS-1:0]      port_readback_o,
  // select configuration
  input  wire logic             cfg_wr_i,
  input  wire win_cfg_t         ucs_cfg_i,
  input  wire win_cfg_t         lcs_cfg_i,
  input  wire win_cfg_t [N_GCS-1:0] gcs_cfg_i,
  input  wire logic [N_GCS-1:0] port_val_i,
  // bus pins
  input  wire logic             ready_i,
  input  wire logic             takeover_request_i,
  input  wire logic             coproc_error_i,
  input  wire logic             coproc_transfer_request_i,
  input  wire logic             lock_in_i,
  output logic                  read_n_o,
  output logic                  write_n_o,
  output logic                  ctrl_oe_o,
  output logic                  transceiver_enable_n_o,
  output logic                  transfer_direction_o,
  output logic                  lock_n_o,
  output logic                  lock_oe_o,
  output logic                  takeover_acknowledge_o,
  output logic                  coproc_select_n_o,
  output logic                  upper_select_n_o,
  output logic                  lower_select_n_o,
  output logic [N_GCS-1:0]      generic_select_n_o
);
  // ------------------------------------------------------------
  // state machine
  // ------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ADDR = 5'b00010,
    ST_DATA = 5'b00100,
    ST_DONE = 5'b01000,
    ST_HOLD = 5'b10000
  } st_t;

  st_t      state;
  st_t      next_state;
  bus_req_t cur;
  win_cfg_t ucs_cfg;
  win_cfg_t lcs_cfg;
  win_cfg_t [N_GCS-1:0] gcs_cfg;
  logic     locked;
  logic     ucs_hit;
  logic     lcs_hit;
  logic [N_GCS-1:0] gcs_hit;
  logic     no_rdy;
  logic     active;
  logic     grant_ok;

  // ------------------------------------------------------------
  // configuration
  // ------------------------------------------------------------
  // R14 upper select reset window, R15 lower off
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ucs_cfg <= '{en: 1'b1, mem: 1'b1, io: 1'b0, no_rdy: 1'b0,
                   lo: UCS_RST_LO, hi: UCS_RST_HI};
      lcs_cfg <= '{en: LCS_RST_EN, mem: 1'b1, io: 1'b0, no_rdy: 1'b0,
                   lo: '0, hi: '0};
      gcs_cfg <= '0;
    end else if (cfg_wr_i) begin
      ucs_cfg <= ucs_cfg_i;
      // R15 memory cycles only
      lcs_cfg <= '{en: lcs_cfg_i.en, mem: 1'b1, io: 1'b0,
                   no_rdy: lcs_cfg_i.no_rdy, lo: lcs_cfg_i.lo, hi: lcs_cfg_i.hi};
      gcs_cfg <= gcs_cfg_i;
    end
  end

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  assign active = (state == ST_ADDR) || (state == ST_DATA);

  // R13 upper window compare
  win_match u_ucs (
    .cfg_i  (ucs_cfg),
    .addr_i (cur.addr),
    .io_i   (cur.io),
    .hit_o  (ucs_hit)
  );

  win_match u_lcs (
    .cfg_i  (lcs_cfg),
    .addr_i (cur.addr),
    .io_i   (cur.io),
    .hit_o  (lcs_hit)
  );

  genvar g;
  generate
    for (g = 0; g < N_GCS; g++) begin : g_gcs
      win_match u_win (
        .cfg_i  (gcs_cfg[g]),
        .addr_i (cur.addr),
        .io_i   (cur.io),
        .hit_o  (gcs_hit[g])
      );
      sel_pin u_pin (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n_i),
        .sel_en_i   (gcs_cfg[g].en),
        .hit_i      (gcs_hit[g] && active && !cur.coproc),
        .port_val_i (port_val_i[g]),
        .pin_n_o    (generic_select_n_o[g])
      );
    end
  endgenerate

  always_comb begin
    no_rdy = (ucs_hit && ucs_cfg.no_rdy) || (lcs_hit && lcs_cfg.no_rdy);
    for (int i = 0; i < N_GCS; i++) begin
      no_rdy = no_rdy || (gcs_hit[i] && gcs_cfg[i].no_rdy);
    end
  end

  // R8 boundary grant, R6 never while locked
  assign grant_ok = takeover_request_i && insn_boundary_i && !locked &&
                    !(req_valid_i && req_i.locked);

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (grant_ok) begin
          next_state = ST_HOLD;
        end else if (req_valid_i) begin
          next_state = ST_ADDR;
        end
      end
      ST_ADDR: next_state = ST_DATA;
      // R3 ready or programmed ignore ends the cycle
      ST_DATA: begin
        if (ready_i || no_rdy) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: next_state = ST_IDLE;
      ST_HOLD: begin
        if (!takeover_request_i) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur <= '0;
    end else if (state == ST_IDLE && next_state == ST_ADDR) begin
      cur <= req_i;
    end
  end

  // lock follows the prefix of each accepted request; also released when idle at an instruction boundary with no request
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      locked <= 1'b0;
    end else if (state == ST_IDLE && next_state == ST_ADDR) begin
      locked <= req_i.locked;
    end else if (state == ST_IDLE && insn_boundary_i && !req_valid_i) begin
      locked <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // pin drive
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      read_n_o               <= 1'b1;
      write_n_o              <= 1'b1;
      transceiver_enable_n_o <= 1'b1;
      transfer_direction_o   <= 1'b0;
      ctrl_oe_o              <= 1'b0;
      takeover_acknowledge_o <= 1'b0;
    end else begin
      // R1 read strobe
      read_n_o <= !(next_state == ST_DATA && !cur.write);
      // R2 write strobe
      write_n_o <= !(next_state == ST_DATA && cur.write);
      // R4 enable only in data phase
      transceiver_enable_n_o <= (next_state != ST_DATA);
      // R5 high when processor drives data out
      if (next_state == ST_ADDR) begin
        transfer_direction_o <= req_i.write;
      end
      // R9 float control before acknowledging
      ctrl_oe_o <= (next_state != ST_HOLD);
      takeover_acknowledge_o <= (next_state == ST_HOLD) && (state == ST_HOLD);
    end
  end

  // R7 lock pin never driven during reset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lock_n_o  <= 1'b1;
      lock_oe_o <= 1'b0;
    end else begin
      lock_n_o  <= !((next_state == ST_ADDR || next_state == ST_DATA) &&
                     (state == ST_IDLE ? req_i.locked : locked));
      lock_oe_o <= (next_state != ST_HOLD);
    end
  end

  // R10 coprocessor select, R18 selects high when idle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      coproc_select_n_o <= 1'b1;
      upper_select_n_o  <= 1'b1;
      lower_select_n_o  <= 1'b1;
    end else begin
      coproc_select_n_o <= !(active && cur.coproc);
      // R13 upper select
      upper_select_n_o  <= !(active && !cur.coproc && ucs_hit);
      // R15 lower select
      lower_select_n_o  <= !(active && !cur.coproc && lcs_hit);
    end
  end

  // ------------------------------------------------------------
  // core side status
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_done_o      <= 1'b0;
      irq_o           <= 1'b0;
      irq_type_o      <= '0;
      xfer_pending_o  <= 1'b0;
      port_readback_o <= {N_GCS{PORT_RST_VAL}};
    end else begin
      req_done_o <= (next_state == ST_DONE);
      // R11 exception at numerics start
      irq_o      <= numerics_start_i && coproc_error_i;
      irq_type_o <= COPROC_IRQ;
      // R12 pending coprocessor transfer
      xfer_pending_o <= coproc_transfer_request_i;
      // R17 pin value readback
      port_readback_o <= generic_select_n_o;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_data_phase;
    !transceiver_enable_n_o;
  endsequence

  a_read_strobe: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R1
    !read_n_o |-> s_data_phase and cur.write == 1'b0)
    else $error("read strobe outside read data phase");
  a_write_strobe: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R2
    !write_n_o |-> s_data_phase and cur.write == 1'b1)
    else $error("write strobe outside write data phase");
  a_ready_wait: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R3
    (state == ST_DATA && !ready_i && !no_rdy) |=> state == ST_DATA)
    else $error("cycle ended without ready");
  a_enable_phase: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R4
    $fell(transceiver_enable_n_o) |-> $past(state) == ST_ADDR)
    else $error("transceiver enable outside data phase");
  a_lock_grant: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R6
    (state == ST_IDLE && locked) |=> state != ST_HOLD)
    else $error("takeover granted while locked");
  a_hold_float: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R9
    takeover_acknowledge_o |-> !ctrl_oe_o && !lock_oe_o)
    else $error("acknowledge while driving bus");
  a_coproc_irq: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R11
    (numerics_start_i && coproc_error_i) |=> irq_o && irq_type_o == 8'h10)
    else $error("coprocessor exception interrupt missing");
  a_select_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R18
    (state == ST_IDLE && $past(state) == ST_IDLE) |-> upper_select_n_o &&
    lower_select_n_o && coproc_select_n_o)
    else $error("select active with no access");

  // direction must match the access type while the transceiver is open
  a_dir_match: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R5
    !transceiver_enable_n_o |-> transfer_direction_o == cur.write)
    else $error("direction disagrees with access type");
  a_lock_cycle: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R6
    !lock_n_o |-> active && locked)
    else $error("lock asserted outside a locked cycle");
  a_hold_boundary: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R8
    (state == ST_IDLE && !insn_boundary_i) |=> state != ST_HOLD)
    else $error("takeover granted off an instruction boundary");
  a_coproc_decode: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R10
    !coproc_select_n_o |-> cur.coproc)
    else $error("coprocessor select on a non-coprocessor access");
  a_ready_done: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R3
    req_done_o |-> $past(ready_i) || $past(no_rdy))
    else $error("access finished without ready or ignore");
endmodule // local_bus_ctrl

// >>> testbench/bus_partner.sv
/*
  memory or i/o device model: answers the strobes with ready.
  assumes strobes are active low and registered on clk_i.
*/
`timescale 1ns/100ps
module bus_partner (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       read_n_i,
  input  wire logic       write_n_i,
  input  wire logic [7:0] wait_i,
  output logic            ready_o
);
  logic [7:0] cnt;
  logic       idle;
  assign idle = read_n_i & write_n_i;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= 8'h00;
    end else if (idle) begin
      cnt <= 8'h00;
    end else if (cnt != 8'hff) begin
      cnt <= cnt + 8'h01;
    end
  end
  // low while unselected, so a stale ready never ends a cycle
  assign ready_o = !idle && (cnt >= wait_i);
endmodule // bus_partner

// >>> testbench/local_bus_control_and_chip_selects_tb.sv
/*
  self-checking bench for local_bus_ctrl.
  assumes one clock; the partner answers strobes with ready.
*/
`timescale 1ns/100ps
module local_bus_control_and_chip_selects_tb;
  import lbc_pkg::*;
  logic clk_i = 0, rst_n_i = 0, req_valid_i = 0, insn_boundary_i = 1;
  logic numerics_start_i = 0, cfg_wr_i = 0, takeover_request_i = 0;
  logic coproc_error_i = 0, coproc_transfer_request_i = 0;
  bus_req_t req_i = '0;
  win_cfg_t ucs_cfg_i = '0, lcs_cfg_i = '0;
  win_cfg_t [GCS_N-1:0] gcs_cfg_i = '0;
  logic [GCS_N-1:0] port_val_i = 8'ha5, port_readback_o, generic_select_n_o, gs;
  logic [IRQ_W-1:0] irq_type_o;
  logic [7:0] wait_cyc = 8'h00;
  logic req_done_o, irq_o, xfer_pending_o, ready_i, read_n_o, write_n_o, ctrl_oe_o;
  logic transceiver_enable_n_o, transfer_direction_o, lock_n_o, lock_oe_o, lock_in_i;
  logic takeover_acknowledge_o, coproc_select_n_o, upper_select_n_o, lower_select_n_o;
  logic rd, wr, transceiver_enable_n, dir, us, ls, ns, lkn, ak;
  int n, bad_count = 0, tests_run = 0;

  always #4 clk_i = ~clk_i;
  assign lock_in_i = lock_oe_o ? lock_n_o : 1'b1;

  local_bus_ctrl u_dut (.clk_i, .rst_n_i, .req_valid_i, .req_i, .insn_boundary_i,
    .numerics_start_i, .req_done_o, .irq_o, .irq_type_o, .xfer_pending_o,
    .port_readback_o, .cfg_wr_i, .ucs_cfg_i, .lcs_cfg_i, .gcs_cfg_i, .port_val_i,
    .ready_i, .takeover_request_i, .coproc_error_i, .coproc_transfer_request_i,
    .lock_in_i, .read_n_o, .write_n_o, .ctrl_oe_o, .transceiver_enable_n_o,
    .transfer_direction_o, .lock_n_o, .lock_oe_o, .takeover_acknowledge_o,
    .coproc_select_n_o, .upper_select_n_o, .lower_select_n_o, .generic_select_n_o);
  bus_partner u_mem (.clk_i, .rst_n_i, .read_n_i(read_n_o), .write_n_i(write_n_o),
    .wait_i(wait_cyc), .ready_o(ready_i));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic tally_and_finish();
    if (bad_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic tmo(input int i, input int lim);
    if (i >= lim) begin
      bad_count++;
      tally_and_finish();
    end
  endtask
  // one access, recording the lowest level seen on each strobe and select pin and the highest on the acknowledge
  task automatic access(input logic w, io, cp, lk, input logic [19:0] a,
                        input logic [7:0] ws);
    int i;
    {rd, wr, transceiver_enable_n, us, ls, ns, lkn, ak, n, gs} = {8'hfe, 32'h0, 8'hff};
    @(posedge clk_i);
    wait_cyc <= ws;
    req_valid_i <= 1'b1;
    req_i <= '{w, io, cp, lk, a};
    for (i = 0; i < 40; i++) begin
      @(negedge clk_i);
      {rd, wr, transceiver_enable_n} &= {read_n_o, write_n_o, transceiver_enable_n_o};
      {us, ls, ns, lkn} &= {upper_select_n_o, lower_select_n_o, coproc_select_n_o, lock_n_o};
      gs &= generic_select_n_o;
      ak |= takeover_acknowledge_o;
      if (transceiver_enable_n_o === 1'b0) dir = transfer_direction_o;
      if ((read_n_o & write_n_o) === 1'b0) n++;
      if (req_done_o === 1'b1) break;
    end
    tmo(i, 40);
    @(posedge clk_i);
    req_valid_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic grant();
    int i;
    for (i = 0; i < 20 && takeover_acknowledge_o !== 1'b1; i++) @(negedge clk_i);
    tmo(i, 20);
    chk(ctrl_oe_o, 0);
    @(posedge clk_i);
    takeover_request_i <= 1'b0;
    for (i = 0; i < 20 && takeover_acknowledge_o !== 1'b0; i++) @(negedge clk_i);
    tmo(i, 20);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk({upper_select_n_o, lower_select_n_o, generic_select_n_o}, 10'h3ff);
    chk({lock_oe_o, takeover_acknowledge_o, port_readback_o}, 10'h0ff);
  endtask
  task automatic t_default();
    access(0, 0, 0, 0, 20'hffc00, 3);
    chk({rd, wr, transceiver_enable_n, dir, us}, 5'h08);
    chk(n >= 4, 1);
    access(1, 0, 0, 0, 20'hfffff, 0);
    chk({rd, wr, dir, us}, 4'ha);
    access(0, 0, 0, 0, 20'hffbff, 0);
    chk(us, 1);
    access(0, 1, 0, 0, 20'hffc00, 0);
    chk({us, ls, gs}, {2'b11, port_val_i});
  endtask
  task automatic t_program();
    @(posedge clk_i);
    ucs_cfg_i <= '{1'b1, 1'b0, 1'b1, 1'b1, 20'h00100, 20'h001ff};
    lcs_cfg_i <= '{1'b1, 1'b1, 1'b0, 1'b0, 20'h00000, 20'h0ffff};
    gcs_cfg_i[0] <= '{1'b1, 1'b1, 1'b1, 1'b0, 20'h20000, 20'h2ffff};
    cfg_wr_i <= 1'b1;
    @(posedge clk_i);
    cfg_wr_i <= 1'b0;
    access(0, 1, 0, 0, 20'h00150, 8'hc8);
    chk(us, 0);
    access(0, 1, 0, 0, 20'h01000, 0);
    chk(ls, 1);
    access(1, 0, 0, 0, 20'h01000, 0);
    chk(ls, 0);
    access(0, 1, 0, 0, 20'h2abcd, 0);
    chk(gs, 8'ha4);
    chk(port_readback_o[7:1], 7'h52);
  endtask
  task automatic t_coproc();
    access(0, 1, 1, 0, 20'h000f8, 0);
    chk(ns, 0);
    for (int e = 0; e < 2; e++) begin
      @(posedge clk_i);
      coproc_error_i <= e[0];
      numerics_start_i <= 1'b1;
      @(posedge clk_i);
      numerics_start_i <= 1'b0;
      ak = 0;
      repeat (4) begin
        @(negedge clk_i);
        ak |= irq_o;
        if (irq_o === 1'b1) chk(irq_type_o, COPROC_IRQ);
      end
      chk(ak, e);
    end
    for (int e = 1; e >= 0; e--) begin
      @(posedge clk_i);
      coproc_transfer_request_i <= e[0];
      @(posedge clk_i);
      @(negedge clk_i);
      chk(xfer_pending_o, e);
    end
  endtask
  task automatic t_takeover();
    @(posedge clk_i);
    insn_boundary_i <= 1'b0;
    takeover_request_i <= 1'b1;
    ak = 0;
    repeat (10) @(negedge clk_i) ak |= takeover_acknowledge_o;
    chk(ak, 0);
    @(posedge clk_i);
    insn_boundary_i <= 1'b1;
    grant();
    fork
      access(0, 0, 0, 1, 20'hffc10, 4);
      begin
        repeat (2) @(posedge clk_i);
        takeover_request_i <= 1'b1;
      end
    join
    chk({lkn, ak}, 0);
    grant();
  endtask

  initial begin
    repeat (2) @(posedge clk_i);
    t_reset();
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_default();
    t_coproc();
    t_takeover();
    t_program();
    tally_and_finish();
  end
endmodule // local_bus_control_and_chip_selects_tb
